/* File: verilog/dios_top.sv */
`timescale 1ns/1ps
// Functional notes
// (R01) host waits 300 ms after reset
// (R02) early accesses end in bus error
// (R03) reset releases lines, clears control
// (R04) 24 lines, one means input, default
// (R05) zero drives low, one releases
// (R06) output address reads back latch
// (R07) word write sets sixteen bits
// (R08) byte and long accesses accepted
// (R09) control bit 0 enables double buffering
// (R10) external strobe at most 1 MHz
// (R11) control bit 1 picks strobe edge
// (R12) control bit 2 takes strobe from line 24
// (R13) software releases line 24 first
// (R14) leader redrives strobe onto line 23
// (R15) software sets line 23 low, 24 high
// (R16) follower from line 24, else normal
// (R17) all lines latch on one edge
// (R18) software sets enable for any source
// (R19) word map 0,2,4,6 and 0xc
// (R20) upper word high byte reads zero
// (R21) inputs captured with output latch clock
// (R22) ack next cycle, extended on hold
// (R23) strobe synchronised, edge detected locally
module dios_top
  import dios_pkg::*;
#(
  parameter int              CFG_CYCLES = CFG_CYCLES_DEF,
  parameter logic [BYTE-1:0] ID_MFR     = ID_MFR_DEF,
  parameter logic [BYTE-1:0] ID_MODEL   = ID_MODEL_DEF,
  parameter logic [BYTE-1:0] ID_REV     = ID_REV_DEF,
  parameter logic [BYTE-1:0] ID_CRC     = ID_CRC_DEF
) (
  // logic clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // carrier bus cycle port
  input  wire logic              io_space_select_n,
  input  wire logic              id_space_select_n,
  input  wire logic              rd_wr_n,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [1:0]        byte_sel_n,
  input  wire logic              hold_req,
  input  wire logic [DW-1:0]     data_in,
  output logic      [DW-1:0]     data_out,
  output logic                   data_oe,
  output logic                   ack_n,
  output logic                   bus_error_n,
  // line side, own clock
  input  wire logic              link_clk,
  input  wire logic              dbl_clk_pin,
  input  wire logic [NLINES-1:0] line_in,
  output logic      [NLINES-1:0] line_out,
  output logic      [NLINES-1:0] line_oe
);
  localparam int CNT_W = $clog2(CFG_CYCLES + 1);
  localparam int PIN_W = NLINES + 1;  // lines plus strobe pin

  // bus side state
  typedef struct packed {
    dios_bus_st_t      bst;       // bus cycle phase
    logic [CNT_W-1:0]  cfg_cnt;   // configuration interval counter
    logic              cfg_done;  // accesses allowed
    logic [NLINES-1:0] out_r;     // output latch
    logic [CTRL_W-1:0] ctrl_r;    // control register
    logic [DW-1:0]     rdata_r;   // read data held for the cycle
    logic              oe_r;      // drive data bus
    logic              ack_r;     // acknowledge
    logic              berr_r;    // bus error
    logic [XFER_W-1:0] xfer_r;    // word handed to line side
    logic              req_t;     // handshake request toggle
    logic              dirty_r;   // latch or control written since last hand-over
    logic              aks1_r;    // ack toggle sync, stage one
    logic              aks2_r;    // ack toggle sync, stage two
    logic              ds1_r;     // input word request sync
    logic              ds2_r;
    logic              ds3_r;
    logic              dack_t;    // input word ack toggle
    logic [NLINES-1:0] din_r;     // direct-read copy
  } dios_bus_t;

  // line side state
  typedef struct packed {
    logic              rq1_r;     // request toggle sync
    logic              rq2_r;
    logic              rq3_r;
    logic              ak_t;      // ack toggle back
    logic [NLINES-1:0] shadow_r;  // local copy of output latch
    logic [CTRL_W-1:0] lctrl_r;   // local copy of control
    logic [PIN_W-1:0]  p1_r;      // pin sync stages
    logic [PIN_W-1:0]  p2_r;
    logic [PIN_W-1:0]  p3_r;
    logic [PIN_W-1:0]  filt_r;    // agreed pin levels
    logic              sprev_r;   // previous selected strobe level
    logic [NLINES-1:0] db_r;      // double buffer latch, drives lines
    logic [NLINES-1:0] din_r;     // input register
    logic [NLINES-1:0] oe_r;      // driver enables
    logic              dk1_r;     // input ack toggle sync
    logic              dk2_r;
    logic              dreq_t;    // input word request toggle
    logic [NLINES-1:0] dxfer_r;   // input word handed to bus side
  } dios_link_t;

  dios_bus_t  c_r, c_nxt;   // bus side registers
  dios_link_t l_r, l_nxt;   // line side registers

  logic sel;        // any select asserted
  logic start;      // new cycle accepted this edge
  logic strb_src;   // selected strobe level
  logic strb_edge;  // selected edge seen
  logic dbl;        // double buffering active on line side
  logic lead;       // leader redrive active

  // io space read decode; unmapped words read zero
  function automatic logic [DW-1:0] io_read(input logic [AW-1:0]     a,
                                            input logic [NLINES-1:0] o,
                                            input logic [NLINES-1:0] d,
                                            input logic [CTRL_W-1:0] k);
    io_read = '0;
    case (a)
      W_OUT_LO: io_read = o[DW-1:0];
      W_OUT_HI: io_read[NLINES-DW-1:0] = o[NLINES-1:DW];  // (R20)
      W_DIN_LO: io_read = d[DW-1:0];
      W_DIN_HI: io_read[NLINES-DW-1:0] = d[NLINES-1:DW];  // (R20)
      W_CTRL:   io_read[CTRL_W-1:0] = k;
      default:  io_read = '0;
    endcase
  endfunction

  // id space: one byte per word, low lane
  function automatic logic [DW-1:0] id_read(input logic [AW-1:0] a);
    id_read = '0;
    case (a)
      6'h00:   id_read[BYTE-1:0] = ID_SIG0;
      6'h01:   id_read[BYTE-1:0] = ID_SIG1;
      6'h02:   id_read[BYTE-1:0] = ID_SIG2;
      6'h03:   id_read[BYTE-1:0] = ID_SIG3;
      6'h04:   id_read[BYTE-1:0] = ID_MFR;
      6'h05:   id_read[BYTE-1:0] = ID_MODEL;
      6'h06:   id_read[BYTE-1:0] = ID_REV;
      6'h0a:   id_read[BYTE-1:0] = ID_USED;
      6'h0b:   id_read[BYTE-1:0] = ID_CRC;
      default: id_read = '0;
    endcase
  endfunction

  assign sel   = ~io_space_select_n | ~id_space_select_n;
  assign start = (c_r.bst == B_IDLE) && sel;

  // bus side next state
  always_comb begin
    c_nxt = c_r;
    // configuration interval; accesses before it finishes get a bus error
    if (!c_r.cfg_done) begin
      if (c_r.cfg_cnt == CNT_W'(CFG_CYCLES - 1)) begin
        c_nxt.cfg_done = 1'b1;
      end else begin
        c_nxt.cfg_cnt = c_r.cfg_cnt + 1'b1;
      end
    end
    unique case (c_r.bst)
      B_IDLE: begin
        // zero wait states: answer on the next edge
        if (sel) begin
          c_nxt.bst = B_ACK;
          if (!c_r.cfg_done) begin
            c_nxt.berr_r = 1'b1;  // (R02)
          end else begin
            c_nxt.ack_r = 1'b1;  // (R22)
            if (rd_wr_n) begin
              c_nxt.oe_r    = 1'b1;
              c_nxt.rdata_r = !io_space_select_n ?
                              io_read(addr, c_r.out_r, c_r.din_r, c_r.ctrl_r) : id_read(addr);  // (R06) (R19)
            end else if (!io_space_select_n) begin
              // byte lanes let byte, word and split long cycles land
              unique case (addr)
                W_OUT_LO: begin
                  if (!byte_sel_n[1]) c_nxt.out_r[DW-1:BYTE] = data_in[DW-1:BYTE];  // (R07) (R08)
                  if (!byte_sel_n[0]) c_nxt.out_r[BYTE-1:0] = data_in[BYTE-1:0];  // (R07) (R08)
                  c_nxt.dirty_r = 1'b1;
                end
                W_OUT_HI: begin
                  // high byte of this word has no lines behind it
                  if (!byte_sel_n[0]) c_nxt.out_r[NLINES-1:DW] = data_in[BYTE-1:0];  // (R20)
                  c_nxt.dirty_r = 1'b1;
                end
                W_CTRL: begin
                  if (!byte_sel_n[0]) c_nxt.ctrl_r = data_in[CTRL_W-1:0];  // (R09) (R11) (R12) (R14)
                  c_nxt.dirty_r = 1'b1;
                end
                default: begin
                  // read-only or unmapped words ignore writes
                end
              endcase
            end
          end
        end
      end
      B_ACK: begin
        // hold cycles stretch the answer
        if (!hold_req) begin  // (R22)
          c_nxt.ack_r  = 1'b0;
          c_nxt.berr_r = 1'b0;
          c_nxt.oe_r   = 1'b0;
          c_nxt.bst    = sel ? B_WAIT : B_IDLE;
        end
      end
      B_WAIT: begin
        // wait for the select to go away so one cycle is answered once
        if (!sel) c_nxt.bst = B_IDLE;
      end
    endcase
    // hand latch and control to the line side, one word at a time
    c_nxt.aks1_r = l_r.ak_t;
    c_nxt.aks2_r = c_r.aks1_r;
    if (c_nxt.dirty_r && (c_r.aks2_r == c_r.req_t)) begin
      c_nxt.xfer_r  = {c_nxt.ctrl_r, c_nxt.out_r};
      c_nxt.req_t   = ~c_r.req_t;
      c_nxt.dirty_r = 1'b0;
    end
    // take the input word from the line side
    c_nxt.ds1_r = l_r.dreq_t;
    c_nxt.ds2_r = c_r.ds1_r;
    c_nxt.ds3_r = c_r.ds2_r;
    if (c_r.ds2_r != c_r.ds3_r) begin
      c_nxt.din_r  = l_r.dxfer_r;  // (R21)
      c_nxt.dack_t = c_r.ds2_r;
    end
  end

  // bus side registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_r          <= '0;
      c_r.bst      <= B_IDLE;
      c_r.out_r    <= OUT_RST;  // (R03) (R04)
      c_r.ctrl_r   <= CTRL_RST;  // (R03)
      c_r.xfer_r   <= {CTRL_RST, OUT_RST};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign data_out    = c_r.rdata_r;
  assign data_oe     = c_r.oe_r;
  assign ack_n       = ~c_r.ack_r;
  assign bus_error_n = ~c_r.berr_r;

  // line side decode
  assign dbl       = l_r.lctrl_r[CB_DBL];
  assign lead      = l_r.lctrl_r[CB_LEAD];
  assign strb_src  = l_r.lctrl_r[CB_MODE] ? l_r.filt_r[LINE_STRB_IN] : l_r.filt_r[NLINES];  // (R12) (R16)
  assign strb_edge = l_r.lctrl_r[CB_POL] ? (l_r.sprev_r & ~strb_src) : (~l_r.sprev_r & strb_src);  // (R11)

  // line side next state
  always_comb begin
    l_nxt = l_r;
    // three stages; a level counts once stages two and three agree
    l_nxt.p1_r   = {dbl_clk_pin, line_in};
    l_nxt.p2_r   = l_r.p1_r;
    l_nxt.p3_r   = l_r.p2_r;
    l_nxt.filt_r = (l_r.p2_r & l_r.p3_r) | (l_r.filt_r & (l_r.p2_r ^ l_r.p3_r));  // (R23)
    // pick up a new latch/control word; xfer is stable by the time the toggle lands
    l_nxt.rq1_r = c_r.req_t;
    l_nxt.rq2_r = l_r.rq1_r;
    l_nxt.rq3_r = l_r.rq2_r;
    if (l_r.rq2_r != l_r.rq3_r) begin
      l_nxt.shadow_r = c_r.xfer_r[NLINES-1:0];
      l_nxt.lctrl_r  = c_r.xfer_r[XFER_W-1:NLINES];
      l_nxt.ak_t     = l_r.rq2_r;
    end
    // remember the level of the source the next edge will use, so a mode change is no edge
    l_nxt.sprev_r = l_nxt.lctrl_r[CB_MODE] ? l_r.filt_r[LINE_STRB_IN] : l_r.filt_r[NLINES];  // (R12)
    // double buffered: snapshot on the chosen edge and hold between edges; not double buffered: follow every cycle
    if (!dbl || strb_edge) begin  // (R09) (R17)
      l_nxt.db_r  = l_r.shadow_r;  // (R17)
      l_nxt.din_r = l_r.filt_r[NLINES-1:0];  // (R21)
    end
    // open collector: a zero bit switches the driver on
    l_nxt.oe_r = ~l_r.db_r;  // (R05)
    if (lead) l_nxt.oe_r[LINE_LEAD_OUT] = ~l_r.filt_r[NLINES];  // (R14)
    // send the input register across
    l_nxt.dk1_r = c_r.dack_t;
    l_nxt.dk2_r = l_r.dk1_r;
    if (l_r.dk2_r == l_r.dreq_t) begin
      l_nxt.dxfer_r = l_r.din_r;
      l_nxt.dreq_t  = ~l_r.dreq_t;
    end
  end

  // line side registers; reset release is not synchronised to link_clk,
  // so the link clock is expected to be quiet or slow at release
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      l_r          <= '0;
      l_r.shadow_r <= OUT_RST;  // (R03)
      l_r.db_r     <= OUT_RST;  // (R03)
      l_r.lctrl_r  <= CTRL_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  // pins only ever pull low
  assign line_out = '0;
  assign line_oe  = l_r.oe_r;

  // bus side checks
  a_early_bus_error: assert property (@(posedge clk) disable iff (!rst_n) // (R02)
    start && !c_r.cfg_done |=> !bus_error_n && ack_n) else $error("early access not refused");
  a_ack_next_cycle: assert property (@(posedge clk) disable iff (!rst_n) // (R22)
    start && c_r.cfg_done |=> !ack_n && bus_error_n) else $error("ack missing after select");
  a_ack_hold_extend: assert property (@(posedge clk) disable iff (!rst_n) // (R22)
    !ack_n && hold_req |=> !ack_n) else $error("ack dropped during hold");
  a_reset_released: assert property (@(posedge clk) disable iff (!rst_n) // (R03)
    !c_r.cfg_done |-> c_r.out_r == OUT_RST && c_r.ctrl_r == CTRL_RST) else $error("reset state lost");
  a_readback_match: assert property (@(posedge clk) disable iff (!rst_n) // (R06)
    start && c_r.cfg_done && rd_wr_n && !io_space_select_n && addr == W_OUT_LO
    |=> data_oe && data_out == $past(c_r.out_r[DW-1:0])) else $error("read back differs from latch");
  a_hi_byte_zero: assert property (@(posedge clk) disable iff (!rst_n) // (R20)
    start && c_r.cfg_done && rd_wr_n && !io_space_select_n && (addr == W_OUT_HI || addr == W_DIN_HI)
    |=> data_out[DW-1:BYTE] == '0) else $error("upper byte not zero");
  a_word_write: assert property (@(posedge clk) disable iff (!rst_n) // (R07)
    start && c_r.cfg_done && !rd_wr_n && !io_space_select_n && addr == W_OUT_LO && byte_sel_n == 2'h0
    |=> c_r.out_r[DW-1:0] == $past(data_in)) else $error("word write not stored");
  a_byte_lane: assert property (@(posedge clk) disable iff (!rst_n) // (R08)
    start && c_r.cfg_done && !rd_wr_n && !io_space_select_n && addr == W_OUT_LO && byte_sel_n == 2'h1
    |=> c_r.out_r[BYTE-1:0] == $past(c_r.out_r[BYTE-1:0])) else $error("masked byte changed");
  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n) // (R09)
    start && c_r.cfg_done && !rd_wr_n && !io_space_select_n && addr == W_CTRL && !byte_sel_n[0]
    |=> c_r.ctrl_r == $past(data_in[CTRL_W-1:0])) else $error("control write lost");

  // line side checks
  a_snap_hold: assert property (@(posedge link_clk) disable iff (!rst_n) // (R17)
    dbl && !strb_edge |=> l_r.db_r == $past(l_r.db_r) && l_r.din_r == $past(l_r.din_r))
    else $error("latch moved without strobe edge");
  a_snap_edge: assert property (@(posedge link_clk) disable iff (!rst_n) // (R11)
    dbl && strb_edge |=> l_r.db_r == $past(l_r.shadow_r) && l_r.din_r == $past(l_r.filt_r[NLINES-1:0]))
    else $error("edge did not latch");
  a_follow_mode: assert property (@(posedge link_clk) disable iff (!rst_n) // (R09)
    !dbl |=> l_r.din_r == $past(l_r.filt_r[NLINES-1:0])) else $error("inputs not transparent");
  a_drive_low: assert property (@(posedge link_clk) disable iff (!rst_n) // (R05)
    ##1 line_oe[LINE_LEAD_OUT-1:0] == ~$past(l_r.db_r[LINE_LEAD_OUT-1:0]) && line_out == '0)
    else $error("driver enable not from latch");
  a_lead_redrive: assert property (@(posedge link_clk) disable iff (!rst_n) // (R14)
    lead ##1 lead |-> line_oe[LINE_LEAD_OUT] == ~$past(l_r.filt_r[NLINES])) else $error("strobe not redriven");

  // scenarios
  c_bus_write: cover property (@(posedge clk) disable iff (!rst_n) start && c_r.cfg_done && !rd_wr_n);
  c_bus_error: cover property (@(posedge clk) disable iff (!rst_n) !bus_error_n);
  c_hold_cycle: cover property (@(posedge clk) disable iff (!rst_n) !ack_n && hold_req);
  c_dbl_edge: cover property (@(posedge link_clk) disable iff (!rst_n) dbl && strb_edge);
  c_lead_mode: cover property (@(posedge link_clk) disable iff (!rst_n) lead && dbl && strb_edge);
endmodule

/* File: common/dios_pkg.sv */
package dios_pkg;
  // line and bus geometry
  localparam int NLINES = 24;
  localparam int DW     = 16;
  localparam int AW     = 6;
  localparam int BYTE   = 8;
  localparam int CTRL_W = 4;
  localparam int XFER_W = NLINES + CTRL_W;

  // word index on the bus address lines a6..a1 (byte offset divided by two)
  localparam logic [AW-1:0] W_OUT_LO = 6'h00;  // byte offset 0x0
  localparam logic [AW-1:0] W_OUT_HI = 6'h01;  // byte offset 0x2
  localparam logic [AW-1:0] W_DIN_LO = 6'h02;  // byte offset 0x4
  localparam logic [AW-1:0] W_DIN_HI = 6'h03;  // byte offset 0x6
  localparam logic [AW-1:0] W_CTRL   = 6'h06;  // byte offset 0xc

  // control register field positions
  localparam int CB_DBL  = 0;  // double buffer enable
  localparam int CB_POL  = 1;  // strobe edge, one = falling
  localparam int CB_MODE = 2;  // strobe taken from line 24
  localparam int CB_LEAD = 3;  // redrive strobe onto line 23

  // special lines, zero based
  localparam int LINE_LEAD_OUT = 22;
  localparam int LINE_STRB_IN  = 23;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [NLINES-1:0] OUT_RST  = 24'hff_ffff;

  // post-reset configuration interval
  localparam int CFG_TIME_MS    = 300;
  localparam int CLK_MHZ        = 250;
  localparam int CFG_CYCLES_DEF = CFG_TIME_MS * 1000 * CLK_MHZ;

  // id space contents; identity values are arbitrary
  localparam logic [BYTE-1:0] ID_SIG0      = 8'h49;
  localparam logic [BYTE-1:0] ID_SIG1      = 8'h50;
  localparam logic [BYTE-1:0] ID_SIG2      = 8'h41;
  localparam logic [BYTE-1:0] ID_SIG3      = 8'h43;
  localparam logic [BYTE-1:0] ID_MFR_DEF   = 8'h5a;  // arbitrary
  localparam logic [BYTE-1:0] ID_MODEL_DEF = 8'h3c;  // arbitrary
  localparam logic [BYTE-1:0] ID_REV_DEF   = 8'h11;  // arbitrary
  localparam logic [BYTE-1:0] ID_USED      = 8'h0c;
  localparam logic [BYTE-1:0] ID_CRC_DEF   = 8'h00;  // arbitrary

  // bus cycle states
  typedef enum logic [1:0] {B_IDLE, B_ACK, B_WAIT} dios_bus_st_t;
endpackage

/* File: bench/dios_carrier.sv */
`timescale 1ns/1ps
module dios_carrier
  import dios_pkg::*;
(
  // logic clock
  input  wire logic          clk,
  // select cycle, toward the device
  output logic               io_space_select_n,
  output logic               id_space_select_n,
  output logic               rd_wr_n,
  output logic [AW-1:0]      addr,
  output logic [1:0]         byte_sel_n,
  output logic               hold_req,
  output logic [DW-1:0]      data_in,
  // device answers
  input  wire logic [DW-1:0] data_out,
  input  wire logic          data_oe,
  input  wire logic          ack_n,
  input  wire logic          bus_error_n
);
  int stood;  // hold cycles during which ack kept standing

  // idle bus from time zero
  initial begin
    io_space_select_n = 1'b1;
    id_space_select_n = 1'b1;
    rd_wr_n           = 1'b1;
    addr              = '0;
    byte_sel_n        = 2'b11;
    hold_req          = 1'b0;
    data_in           = '0;
    stood             = 0;
  end

  // one select cycle; resp 0 = ack, 1 = bus error, 2 = no answer
  task automatic cycle(input logic id, input logic rd, input logic [AW-1:0] a, input logic [1:0] bs,
                       input logic [DW-1:0] wd, input int h, output logic [DW-1:0] rdat,
                       output logic [1:0] resp);
    int n;
    n = 0;
    @(negedge clk);
    io_space_select_n = id;
    id_space_select_n = ~id;
    rd_wr_n           = rd;
    addr              = a;
    byte_sel_n        = bs;
    data_in           = wd;
    hold_req          = (h > 0);
    // answers are registered, so falling edges see them settled
    do begin
      @(negedge clk);
      n++;
    end while (ack_n !== 1'b0 && bus_error_n !== 1'b0 && n < 20);
    // an unknown or double answer counts as none
    resp = (ack_n === 1'b0 && bus_error_n === 1'b1) ? 2'd0 :
           ((bus_error_n === 1'b0 && ack_n === 1'b1) ? 2'd1 : 2'd2);
    rdat = (data_oe === 1'b1) ? data_out : 16'hxxxx;
    stood = 0;
    // hold must keep the answer standing
    repeat (h) begin
      @(negedge clk);
      if (ack_n === 1'b0) stood++;
    end
    hold_req          = 1'b0;
    io_space_select_n = 1'b1;
    id_space_select_n = 1'b1;
    byte_sel_n        = 2'b11;
    data_in           = ~wd;  // released data never repeats the last value
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import dios_pkg::*;
  localparam int CFG = 16;  // shortened configuration interval

  logic              clk;
  logic              link_clk;
  logic              rst_n;
  logic              dbl_clk_pin;
  logic              io_space_select_n;
  logic              id_space_select_n;
  logic              rd_wr_n;
  logic [AW-1:0]     addr;
  logic [1:0]        byte_sel_n;
  logic              hold_req;
  logic [DW-1:0]     data_in;
  logic [DW-1:0]     data_out;
  logic              data_oe;
  logic              ack_n;
  logic              bus_error_n;
  logic [NLINES-1:0] line_in;
  logic [NLINES-1:0] line_out;
  logic [NLINES-1:0] line_oe;
  logic [NLINES-1:0] ext_low;  // far-side sinks on the lines
  logic              jumper;   // line 23 wired back to line 24
  logic [DW-1:0]     rd;
  logic [1:0]        er;
  int                fails;
  int                n_checks;

  // open collector: pull-ups win unless someone sinks
  assign line_in = ~(line_oe | ext_low | {jumper & line_oe[LINE_LEAD_OUT], {(NLINES-1){1'b0}}});

  // logic clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // link clock, 12 ns, phase unrelated
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #6 link_clk = ~link_clk;
  end

  dios_top #(.CFG_CYCLES(CFG)) DUT (
    .clk(clk), .rst_n(rst_n), .io_space_select_n(io_space_select_n), .id_space_select_n(id_space_select_n),
    .rd_wr_n(rd_wr_n), .addr(addr), .byte_sel_n(byte_sel_n), .hold_req(hold_req), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ack_n(ack_n), .bus_error_n(bus_error_n), .link_clk(link_clk),
    .dbl_clk_pin(dbl_clk_pin), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));

  dios_carrier carrier (
    .clk(clk), .io_space_select_n(io_space_select_n), .id_space_select_n(id_space_select_n),
    .rd_wr_n(rd_wr_n), .addr(addr), .byte_sel_n(byte_sel_n), .hold_req(hold_req), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ack_n(ack_n), .bus_error_n(bus_error_n));

  // value compare
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bus response compare
  task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // plain word write, answer must be ack
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    carrier.cycle(1'b0, 1'b0, a, 2'b00, d, 0, rd, er);
    chk_resp("write resp", 2'd0, er);
  endtask

  // word read compared with an expected value
  task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    carrier.cycle(1'b0, 1'b1, a, 2'b00, 16'h0000, 0, rd, er);
    chk_resp("read resp", 2'd0, er);
    chk_val("read data", {16'h0000, exp}, {16'h0000, rd});
  endtask

  // line enables cross a clock domain: poll, bounded
  task automatic wait_oe(input logic [NLINES-1:0] exp);
    int n;
    n = 0;
    while (line_oe !== exp && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk_val("line_oe", {8'h00, exp}, {8'h00, line_oe});
  endtask

  // strobe edge, spaced so the strobe stays at or under 1 MHz
  task automatic strobe(input logic v);
    repeat (260) @(negedge clk);
    dbl_clk_pin = v;
  endtask

  // single exit of the run
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end

  // main sequence
  initial begin
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    dbl_clk_pin = 1'b0;
    ext_low = '0;
    jumper = 1'b0;
    repeat (20) @(negedge clk);
    chk_val("oe in reset", 32'h0000_0000, {8'h00, line_oe});
    chk_val("line_out", 32'h0000_0000, {8'h00, line_out});
    rst_n = 1'b1;
    // too early: bus error and no write
    carrier.cycle(1'b0, 1'b0, W_OUT_LO, 2'b00, 16'h0000, 0, rd, er);
    chk_resp("early resp", 2'd1, er);
    repeat (CFG + 4) @(negedge clk);
    rdchk(W_CTRL, 16'h0000);
    rdchk(W_OUT_LO, 16'hffff);
    rdchk(W_OUT_HI, 16'h00ff);
    wr(W_OUT_LO, 16'h5a3c);
    rdchk(W_OUT_LO, 16'h5a3c);
    wait_oe(24'h00_a5c3);
    wr(W_OUT_HI, 16'hab7f);
    rdchk(W_OUT_HI, 16'h007f);
    // upper lane only
    carrier.cycle(1'b0, 1'b0, W_OUT_LO, 2'b01, 16'h0f77, 0, rd, er);
    chk_resp("lane resp", 2'd0, er);
    rdchk(W_OUT_LO, 16'h0f3c);
    wait_oe(24'h80_f0c3);
    ext_low = 24'h00_0101;
    repeat (60) @(negedge clk);
    rdchk(W_DIN_LO, 16'h0e3c);
    rdchk(W_DIN_HI, 16'h007f);
    rdchk(6'h05, 16'h0000);
    // hold stretches the answer
    carrier.cycle(1'b0, 1'b1, W_OUT_HI, 2'b00, 16'h0000, 2, rd, er);
    chk_resp("hold resp", 2'd0, er);
    chk_val("hold data", 32'h0000_007f, {16'h0000, rd});
    chk_val("ack stood", 32'd2, carrier.stood);
    carrier.cycle(1'b1, 1'b1, 6'd10, 2'b00, 16'h0000, 0, rd, er);
    chk_resp("id resp", 2'd0, er);
    chk_val("id word", {24'h00_0000, ID_USED}, {24'h00_0000, rd[7:0]});
    wr(W_OUT_LO, 16'hffff);
    wr(W_OUT_HI, 16'h00ff);
    wait_oe(24'h00_0000);
    // double buffered, rising edge
    wr(W_CTRL, 16'h0001);
    rdchk(W_CTRL, 16'h0001);
    wr(W_OUT_LO, 16'h00ff);
    ext_low = 24'h00_0002;
    repeat (60) @(negedge clk);
    chk_val("oe held", 32'h0000_0000, {8'h00, line_oe});
    rdchk(W_DIN_LO, 16'hfefe);
    strobe(1'b1);
    wait_oe(24'h00_ff00);
    repeat (40) @(negedge clk);
    rdchk(W_DIN_LO, 16'hfffd);
    // falling edge selected
    wr(W_CTRL, 16'h0003);
    wr(W_OUT_LO, 16'hffff);
    strobe(1'b0);
    wait_oe(24'h00_0000);
    wr(W_OUT_LO, 16'hff00);
    strobe(1'b1);
    repeat (60) @(negedge clk);
    chk_val("rise ignored", 32'h0000_0000, {8'h00, line_oe});
    strobe(1'b0);
    wait_oe(24'h00_00ff);
    // follower: strobe from line 24, line 24 left released
    wr(W_CTRL, 16'h0005);
    wr(W_OUT_LO, 16'hffff);
    strobe(1'b1);
    repeat (60) @(negedge clk);
    chk_val("pin ignored", 32'h0000_00ff, {8'h00, line_oe});
    ext_low = 24'h80_0000;
    repeat (260) @(negedge clk);
    ext_low = 24'h00_0000;
    wait_oe(24'h00_0000);
    // leader: line 23 driven, line 24 receives
    wr(W_CTRL, 16'h0000);
    wr(W_OUT_HI, 16'h00bf);
    wait_oe(24'h40_0000);
    wr(W_CTRL, 16'h000d);
    rdchk(W_CTRL, 16'h000d);
    wait_oe(24'h00_0000);
    // redriven strobe loops back into line 24 and clocks the latch
    jumper = 1'b1;
    wr(W_OUT_LO, 16'h00ff);
    strobe(1'b0);
    wait_oe(24'h40_0000);
    strobe(1'b1);
    wait_oe(24'h00_ff00);
    // reset in mid-run
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk_val("oe second reset", 32'h0000_0000, {8'h00, line_oe});
    rst_n = 1'b1;
    repeat (CFG + 4) @(negedge clk);
    rdchk(W_CTRL, 16'h0000);
    tally_and_finish;
  end
endmodule
